/* File: sses_pkg.sv */
package sses_pkg;

    // Clock and time base.
    localparam int CLK_PERIOD_NS = 10;
    localparam int FIRST_DELAY_NS = 1100000;
    localparam int HOLD_PERIOD_NS = 93000;
    localparam int GOOD_DELAY_NS = 93000;
    localparam int FIRST_DELAY_CYC = FIRST_DELAY_NS / CLK_PERIOD_NS;
    localparam int HOLD_PERIOD_CYC = HOLD_PERIOD_NS / CLK_PERIOD_NS;
    localparam int GOOD_DELAY_CYC = GOOD_DELAY_NS / CLK_PERIOD_NS;
    localparam int DLY_W = 17;

    // Enable comparator thresholds in millivolts.
    localparam logic [11:0] EN_RISE_MV = 12'h35c;
    localparam logic [11:0] EN_HYST_MV = 12'h068;
    localparam logic [11:0] EN_FALL_MV = EN_RISE_MV - EN_HYST_MV;

    // Reference levels in 6.25 mV steps.
    localparam int LVL_W = 9;
    localparam logic [8:0] STARTUP_LEVEL = 9'h0b0;
    localparam logic [8:0] CODE_MIN = 9'h001;

    // Soft-start oscillator: one step every (divider + 1) clocks.
    localparam logic [15:0] STEP_DIV_RST = 16'h01f3;

    // Register byte offsets.
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STEP_DIV = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_LEVEL = 12'h00c;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam int LEVEL_TGT_LSB = 16;

    // Channel-one low gate rail selection.
    typedef enum logic [1:0] {
        SSES_RAIL_NORMAL,
        SSES_RAIL_LOW_GND,
        SSES_RAIL_LOW_SUPPLY
    } sses_rail_t;

    // Per-phase comparator indications.
    typedef struct packed {
        logic pwm;
        logic low_gate_below;
        logic high_gate_below;
        logic phase_below;
    } sses_phase_in_t;

endpackage

/* File: sses_sequencer.sv */
`timescale 1ns/1ns
module sses_sequencer #(
    parameter int NPH = 3,
    parameter int FIRST_DELAY = sses_pkg::FIRST_DELAY_CYC,
    parameter int HOLD_DELAY = sses_pkg::HOLD_PERIOD_CYC,
    parameter int GOOD_DELAY = sses_pkg::GOOD_DELAY_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] enable_mv,
    input wire logic controller_supply_ok,
    input wire logic [NPH-1:0] driver_supply_ok,
    input wire logic [7:0] voltage_code,
    input wire logic [sses_pkg::LVL_W-1:0] feedback_node,
    input wire sses_pkg::sses_phase_in_t [NPH-1:0] phase_in,
    input wire logic light_load_indicator,
    input wire logic ramp_resistor_to_supply,
    output logic [NPH-1:0] high_side_gate,
    output logic [NPH-1:0] low_side_gate,
    output logic regulator_good_flag,
    output sses_pkg::sses_rail_t gate_rail_out,
    output logic [sses_pkg::LVL_W-1:0] reference_level
);
    import sses_pkg::*;

    typedef enum logic [2:0] {
        ST_SHUT,
        ST_DELAY1,
        ST_RAMP1,
        ST_HOLD,
        ST_RAMP2,
        ST_GOOD_WAIT,
        ST_RUN
    } sses_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus.
    ////////////////////////////////////////////////////////////////////////////

    logic run_en_q;
    logic [15:0] step_div_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic en_on_q;
    logic drv_en_q;
    logic good_q;
    logic [LVL_W-1:0] ref_q;
    logic [LVL_W-1:0] tgt_q;
    sses_state_t st_q;

    // Address decode; the answer is prepared in the setup cycle.
    wire setup_phase = psel && !penable;
    wire wr_take = psel && penable && pwrite;
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_div = (paddr == OFS_STEP_DIV);
    wire hit_stat = (paddr == OFS_STATUS);
    wire hit_lvl = (paddr == OFS_LEVEL);
    wire hit_any = hit_ctrl || hit_div || hit_stat || hit_lvl;
    wire [31:0] stat_word = {24'h000000, 1'b0, 3'(st_q), good_q, drv_en_q, en_on_q, run_en_q};
    wire [31:0] lvl_word = (32'(tgt_q) << LEVEL_TGT_LSB) | 32'(ref_q);
    wire [31:0] rd_word = hit_ctrl ? {31'h00000000, run_en_q} :
                          hit_div ? {16'h0000, step_div_q} :
                          hit_stat ? stat_word :
                          hit_lvl ? lvl_word : 32'h00000000;

    // One wait-free access: pready rises in the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup_phase;
            pslverr_q <= setup_phase && !hit_any;
            prdata_q <= (setup_phase && !pwrite) ? rd_word : 32'h00000000;
        end
    end

    // Writable control registers take effect at the completing edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_en_q <= CTRL_RUN_RST;
            step_div_q <= STEP_DIV_RST;
        end else if (wr_take && pready_q) begin
            if (hit_ctrl) begin
                run_en_q <= pwdata[CTRL_RUN_BIT];
            end
            if (hit_div) begin
                step_div_q <= pwdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start qualification.
    ////////////////////////////////////////////////////////////////////////////

    wire en_on_d = en_on_q ? (enable_mv >= EN_FALL_MV) : (enable_mv > EN_RISE_MV);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_on_q <= 1'b0;
        end else begin
            en_on_q <= en_on_d;
        end
    end

    wire start_ok = controller_supply_ok && en_on_q && (&driver_supply_ok) && run_en_q;

    ////////////////////////////////////////////////////////////////////////////
    // Soft-start sequence.
    ////////////////////////////////////////////////////////////////////////////

    logic [DLY_W-1:0] dly_q;
    logic [15:0] tick_cnt_q;
    sses_state_t st_d;

    wire ramping = (st_q == ST_RAMP1) || (st_q == ST_RAMP2);
    wire tick = ramping && (tick_cnt_q >= step_div_q);
    wire [LVL_W-1:0] code_lvl = {1'b0, voltage_code};
    wire code_valid = (code_lvl >= CODE_MIN);
    wire d1_done = (dly_q == DLY_W'(FIRST_DELAY - 1));
    wire hold_done = (dly_q == DLY_W'(HOLD_DELAY - 1));
    wire good_done = (dly_q == DLY_W'(GOOD_DELAY - 1));
    wire ramp1_done = (ref_q == STARTUP_LEVEL);
    wire ramp2_done = (ref_q == tgt_q);
    wire state_change = (st_d != st_q);

    // Next state; a lost start condition always wins and restarts.
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_SHUT: begin
                if (start_ok) begin
                    st_d = ST_DELAY1;
                end
            end
            ST_DELAY1: begin
                if (d1_done) begin
                    st_d = ST_RAMP1;
                end
            end
            ST_RAMP1: begin
                if (ramp1_done) begin
                    st_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (hold_done && code_valid) begin
                    st_d = ST_RAMP2;
                end
            end
            ST_RAMP2: begin
                if (ramp2_done) begin
                    st_d = ST_GOOD_WAIT;
                end
            end
            ST_GOOD_WAIT: begin
                if (good_done) begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                st_d = ST_RUN;
            end
            default: begin
                st_d = ST_SHUT;
            end
        endcase
        if (!start_ok) begin
            st_d = ST_SHUT;
        end
    end

    // State and delay counter; the counter restarts on every state change and when a hold repeats.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_SHUT;
            dly_q <= '0;
        end else begin
            st_q <= st_d;
            dly_q <= (state_change || ((st_q == ST_HOLD) && hold_done)) ? '0 : dly_q + 1'b1;
        end
    end

    // Oscillator divider runs only while ramping.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= (!ramping || tick) ? '0 : tick_cnt_q + 1'b1;
        end
    end

    // Reference moves one step per tick toward the goal of the ramp.
    wire [LVL_W-1:0] goal = (st_q == ST_RAMP1) ? STARTUP_LEVEL : tgt_q;
    wire [LVL_W-1:0] ref_step = (ref_q < goal) ? ref_q + 1'b1 :
                                (ref_q > goal) ? ref_q - 1'b1 : ref_q;

    // code is expected settled when sampled at hold end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q <= '0;
            tgt_q <= '0;
        end else if (st_q == ST_SHUT) begin
            ref_q <= '0;
            tgt_q <= '0;
        end else begin
            ref_q <= tick ? ref_step : ref_q;
            tgt_q <= (st_q == ST_HOLD && hold_done) ? code_lvl : tgt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pre-biased start and power-good.
    ////////////////////////////////////////////////////////////////////////////

    // drives off in soft-start until reference exceeds feedback
    wire in_ss = ramping || (st_q == ST_HOLD);
    wire past_ss = (st_q == ST_GOOD_WAIT) || (st_q == ST_RUN);
    wire drv_en_d = past_ss || (in_ss && (drv_en_q || (ref_q > feedback_node)));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_en_q <= 1'b0;
            good_q <= 1'b0;
        end else begin
            drv_en_q <= drv_en_d;
            good_q <= (st_q == ST_RUN) && start_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gate drive with adaptive dead time.
    ////////////////////////////////////////////////////////////////////////////

    logic [NPH-1:0] hs_q;
    logic [NPH-1:0] ls_q;
    wire gates_allowed = drv_en_q && (st_q != ST_SHUT) && start_ok;

    for (genvar i = 0; i < NPH; i++) begin : g_phase
        // high gate waits for low gate below threshold
        wire hs_d = gates_allowed && phase_in[i].pwm && phase_in[i].low_gate_below && !ls_q[i];
        // low gate after high gate or phase falls
        wire ls_d = gates_allowed && !phase_in[i].pwm && !hs_q[i] &&
                    (phase_in[i].high_gate_below || phase_in[i].phase_below);

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                hs_q[i] <= 1'b0;
                ls_q[i] <= 1'b0;
            end else begin
                hs_q[i] <= hs_d;
                ls_q[i] <= ls_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Light-load rail selection.
    ////////////////////////////////////////////////////////////////////////////

    sses_rail_t rail_q;

    wire sses_rail_t rail_d = sses_rail_t'(light_load_indicator ? SSES_RAIL_NORMAL :
                              ramp_resistor_to_supply ? SSES_RAIL_LOW_SUPPLY : SSES_RAIL_LOW_GND);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rail_q <= SSES_RAIL_NORMAL;
        end else begin
            rail_q <= rail_d;
        end
    end

    // Outputs come straight from flip-flops.
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign high_side_gate = hs_q;
    assign low_side_gate = ls_q;
    assign regulator_good_flag = good_q;
    assign gate_rail_out = rail_q;
    assign reference_level = ref_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    ////////////////////////////////////////////////////////////////////////////

    a_shut_gates_low: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == ST_SHUT |=> (hs_q == '0) && (ls_q == '0))
        else $error("Gate driven while in shutdown.");

    a_enable_hyst: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(en_on_q) |-> $past(enable_mv) > EN_RISE_MV)
        else $error("Enable asserted below rising threshold.");

    a_start_needs_all: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_SHUT) && !start_ok |=> st_q == ST_SHUT)
        else $error("Left shutdown without start conditions.");

    a_first_delay_len: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_RAMP1) && ($past(st_q) == ST_DELAY1) |-> $past(dly_q) == DLY_W'(FIRST_DELAY - 1))
        else $error("First delay has wrong length.");

    a_hold_level: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == ST_HOLD |-> ref_q == STARTUP_LEVEL)
        else $error("Reference not at startup level during hold.");

    a_ramp_one_step: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(ref_q) && $past(st_q) != ST_SHUT |->
            (ref_q == $past(ref_q) + 1'b1) || (ref_q == $past(ref_q) - 1'b1))
        else $error("Reference moved by more than one step.");

    a_good_after_run: assert property (@(posedge pclk) disable iff (!presetn)
        st_q != ST_RUN |=> !good_q)
        else $error("Power-good high before soft-start finished.");

    a_prebias_off: assert property (@(posedge pclk) disable iff (!presetn)
        in_ss && !drv_en_q |=> (hs_q == '0) && (ls_q == '0))
        else $error("Gate driven while feedback above reference.");

    a_high_deadtime: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(hs_q[0]) |-> $past(phase_in[0].low_gate_below) && !$past(ls_q[0]))
        else $error("High gate rose before low gate fell.");

    a_lost_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q != ST_SHUT) && !start_ok |=> st_q == ST_SHUT)
        else $error("Did not return to shutdown on lost condition.");

    a_rail_select: assert property (@(posedge pclk) disable iff (!presetn)
        !light_load_indicator && ramp_resistor_to_supply |=> rail_q == SSES_RAIL_LOW_SUPPLY)
        else $error("Wrong rail level in light load.");

    c_reach_run: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(good_q));

    c_prebias_enable: cover property (@(posedge pclk) disable iff (!presetn)
        in_ss && $rose(drv_en_q) && (feedback_node != '0));

    c_restart: cover property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_RAMP2) ##1 (st_q == ST_SHUT));

    c_ramp_down: cover property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_RAMP2) && tick && (tgt_q < ref_q));

endmodule

/* File: sses_cpu_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
// Processor side: drives the enable pin level and the voltage code.
module sses_cpu_model #(
    parameter int LAG = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] mv_req,
    input wire logic [7:0] code_req,
    output logic [11:0] enable_mv,
    output logic [7:0] voltage_code
);
    logic [7:0] code_q [LAG];

    // The enable level follows the request one clock later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_mv <= 12'h000;
        end else begin
            enable_mv <= mv_req;
        end
    end

    // code settles early
    // A new code appears LAG clocks after the request, far inside the settle window.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < LAG; i++) code_q[i] <= 8'h00;
        end else begin
            code_q[0] <= code_req;
            for (int i = 1; i < LAG; i++) code_q[i] <= code_q[i-1];
        end
    end

    assign voltage_code = code_q[LAG-1];
endmodule

/* File: softstart_enable_sequencer_test.sv */
`timescale 1ns/1ns
module softstart_enable_sequencer_test;
    import sses_pkg::*;
    localparam int NPH = 3;
    localparam int FD = 20;
    localparam int HD = 10;
    localparam int GD = 10;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic controller_supply_ok, light_load_indicator, ramp_resistor_to_supply, regulator_good_flag;
    logic [11:0] paddr, mv_req, enable_mv;
    logic [31:0] pwdata, prdata, rd;
    logic [NPH-1:0] driver_supply_ok, high_side_gate, low_side_gate;
    logic [7:0] code_req, voltage_code;
    logic [LVL_W-1:0] feedback_node, reference_level;
    sses_phase_in_t [NPH-1:0] phase_in;
    sses_rail_t gate_rail_out;
    int n_errors = 0;
    int comparisons = 0;
    logic [11:0] mvs [4] = '{12'h35d, 12'h320, 12'h2f3, 12'h35c};
    logic ons [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

    sses_sequencer #(.NPH(NPH), .FIRST_DELAY(FD), .HOLD_DELAY(HD), .GOOD_DELAY(GD)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .enable_mv(enable_mv), .controller_supply_ok(controller_supply_ok),
        .driver_supply_ok(driver_supply_ok), .voltage_code(voltage_code), .feedback_node(feedback_node),
        .phase_in(phase_in), .light_load_indicator(light_load_indicator),
        .ramp_resistor_to_supply(ramp_resistor_to_supply), .high_side_gate(high_side_gate),
        .low_side_gate(low_side_gate), .regulator_good_flag(regulator_good_flag),
        .gate_rail_out(gate_rail_out), .reference_level(reference_level));

    sses_cpu_model CPU (.pclk(pclk), .presetn(presetn), .mv_req(mv_req), .code_req(code_req),
        .enable_mv(enable_mv), .voltage_code(voltage_code));

    // Free-running bus clock.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic window(input int v, input int lo, input int hi);
        comparisons++;
        if (v < lo || v > hi) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask

    task automatic results();
        $display("Errors %0d in %0d comparisons", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic ph(input logic [3:0] v);
        phase_in <= {NPH{v}};
    endtask

    // One APB transfer; read data and error are taken at the edge where pready is seen.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_errors++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] rnd_code(input int hi);
        logic [7:0] c;
        c = 8'($urandom_range(hi, 1));
        return (c == 8'hb0) ? 8'hb1 : c;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Full start-up with an integer model of the timing, checked every cycle.
    task automatic run_seq(input logic [7:0] code, input logic [15:0] dv, input logic [8:0] fb);
        int t, prev, last, t_hold, t_fin, t_x;
        logic [8:0] r;
        prev = 0;
        last = -1;
        t_hold = -1;
        t_fin = -1;
        t_x = -1;
        mv_req <= 12'h000;
        cyc(4);
        apb(1'b1, OFS_STEP_DIV, {16'h0000, dv});
        feedback_node <= fb;
        code_req <= code;
        ph(4'hc);
        cyc(10);
        mv_req <= 12'h384;
        for (t = 0; t < 6000 && regulator_good_flag !== 1'b1; t++) begin
            @(negedge pclk);
            r = reference_level;
            if (t_x < 0 && t_fin < 0) check({high_side_gate, low_side_gate}, 0);
            if (t_fin < 0) check(regulator_good_flag, 1'b0);
            if (t_x >= 0 && t == t_x + 4) check(high_side_gate, {NPH{1'b1}});
            if (r != prev) begin
                check(r - prev == 1 || prev - r == 1, 1'b1);
                if (last >= 0 && prev != 0 && prev != STARTUP_LEVEL) check(t - last, dv + 1);
                if (prev == 0) window(t, FD, FD + dv + 6);
                if (prev == STARTUP_LEVEL) window(t - t_hold, HD, HD + 2 * dv + 5);
                last = t;
                prev = r;
            end
            if (r == STARTUP_LEVEL && t_hold < 0) t_hold = t;
            if (t_hold >= 0 && r == {1'b0, code} && t_fin < 0) t_fin = t;
            if (r > fb && t_x < 0) t_x = t;
        end
        if (regulator_good_flag !== 1'b1) begin
            n_errors++;
            results();
        end
        check(t_hold >= 0, 1'b1);
        window(t - 1 - t_fin, GD, GD + 4);
        check(high_side_gate, {NPH{1'b1}});
        apb(1'b0, OFS_LEVEL, 32'h0);
        check(rd, {8'h00, code, 8'h00, code});
        $display("test start-up to code %h done", code);
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, controller_supply_ok, light_load_indicator, ramp_resistor_to_supply} = 6'h08;
        paddr = 12'h000;
        pwdata = 32'h0;
        mv_req = 12'h000;
        code_req = 8'h00;
        driver_supply_ok = '0;
        feedback_node = 9'h000;
        phase_in = '0;
        cyc(16);
        presetn <= 1'b1;
        void'($urandom(32'hfd8b));
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd[0], CTRL_RUN_RST);
        apb(1'b0, OFS_STEP_DIV, 32'h0);
        check(rd, {16'h0000, STEP_DIV_RST});
        apb(1'b0, 12'h010, 32'h0);
        check(er, 1'b1);
        check(rd, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            ph(4'($urandom));
            cyc(2);
            check({high_side_gate, low_side_gate}, 0);
        end
        for (int i = 0; i < 4; i++) begin
            light_load_indicator <= i[1];
            ramp_resistor_to_supply <= i[0];
            cyc(3);
            check(gate_rail_out, i[1] ? SSES_RAIL_NORMAL : (i[0] ? SSES_RAIL_LOW_SUPPLY : SSES_RAIL_LOW_GND));
        end
        $display("test shutdown gates and rail done");
        controller_supply_ok <= 1'b1;
        driver_supply_ok <= ~(3'b001 << $urandom_range(NPH - 1));
        foreach (mvs[i]) begin
            mv_req <= mvs[i];
            cyc(4);
            apb(1'b0, OFS_STATUS, 32'h0);
            check(rd[1], ons[i]);
            check(rd[6:4], 3'h0);
        end
        driver_supply_ok <= '1;
        apb(1'b1, OFS_CTRL, 32'h0);
        mv_req <= 12'h384;
        cyc(4);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[6:0], 7'h02);
        mv_req <= 12'h000;
        cyc(4);
        apb(1'b1, OFS_CTRL, 32'h1);
        $display("test enable qualification done");
        run_seq(rnd_code(255), 16'h0000, 9'h000);
        ph(4'h8);
        cyc(4);
        check(high_side_gate, 0);
        ph(4'hc);
        cyc(3);
        check(high_side_gate, {NPH{1'b1}});
        for (int i = 0; i < 2; i++) begin
            ph(4'h0);
            cyc(4);
            check(low_side_gate, 0);
            ph(i == 0 ? 4'h2 : 4'h1);
            cyc(3);
            check(low_side_gate, {NPH{1'b1}});
        end
        $display("test dead time done");
        controller_supply_ok <= 1'b0;
        cyc(3);
        check({regulator_good_flag, reference_level, high_side_gate, low_side_gate}, 0);
        controller_supply_ok <= 1'b1;
        run_seq(rnd_code(255), 16'($urandom_range(3)), 9'h064);
        driver_supply_ok <= ~(3'b001 << $urandom_range(NPH - 1));
        cyc(3);
        check({regulator_good_flag, reference_level, high_side_gate, low_side_gate}, 0);
        driver_supply_ok <= '1;
        run_seq(rnd_code(150), 16'($urandom_range(3)), 9'h0c8);
        results();
    end
endmodule
